// *** design/sgp_pkg.sv ***
// Shared constants and carrier types for the gauge bus port
package sgp_pkg;
  localparam logic [6:0] SGP_OWN_ADDR     = 7'h0B;
  localparam logic [6:0] SGP_CHARGER_ADDR = 7'h09;
  localparam logic [6:0] SGP_HOST_ADDR    = 7'h08;
  localparam logic [7:0] SGP_CRC_POLY     = 8'h07;
  localparam logic [7:0] SGP_CRC_INIT     = 8'h00;
  localparam int         SGP_CLK_MHZ      = 200;
  localparam int         SGP_OFF_MS       = 2000;
  localparam int         SGP_ON_US        = 1000;
  localparam int         SGP_OFF_CYCLES   = SGP_OFF_MS * 1000 * SGP_CLK_MHZ;
  localparam int         SGP_ON_CYCLES    = SGP_ON_US * SGP_CLK_MHZ;
  localparam int         SGP_MDIV         = 500;
  localparam int         SGP_FIFO_DEPTH   = 8;
  localparam int         SGP_BLOCK_MAX    = 32;

  // Slave-side access presented to the gauge core
  typedef struct packed {
    logic       wr;
    logic [7:0] cmd;
    logic [15:0] data;
    logic       pec;
  } sgp_req_t;

  // Master broadcast request: target, command, word
  typedef struct packed {
    logic       to_host;
    logic [7:0] cmd;
    logic [15:0] data;
  } sgp_bcast_t;

  function automatic logic [7:0] sgp_crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ SGP_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : sgp_crc8
endpackage : sgp_pkg

// *** design/sgp_fifo.sv ***
// Small flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sgp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt != DEPTH[AW:0]);
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sgp_fifo

// *** design/sgp_bit_sync.sv ***
// Two-flop synchroniser with edge and condition detection for the bus pins
`timescale 1ns/1ps
module sgp_bit_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Raw pins
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  // Synchronised view
  output logic      scl,
  output logic      sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic [1:0] scl_ff;
  logic [1:0] sda_ff;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_ff <= 2'h3;
      sda_ff <= 2'h3;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_ff <= {scl_ff[0], scl_pin};
      sda_ff <= {sda_ff[0], sda_pin};
      scl_d  <= scl_ff[1];
      sda_d  <= sda_ff[1];
    end
  end

  assign scl       = scl_ff[1];
  assign sda       = sda_ff[1];
  assign scl_rise  = scl_ff[1] && !scl_d;
  assign scl_fall  = !scl_ff[1] && scl_d;
  assign start_det = scl_ff[1] && scl_d && sda_d && !sda_ff[1]; // RL1
  assign stop_det  = scl_ff[1] && scl_d && !sda_d && sda_ff[1]; // RL2
endmodule : sgp_bit_sync

// *** design/sgp_port.sv ***
// Bus port of the gauge: slave transfers, master broadcasts, PEC, off-state
`timescale 1ns/1ps
import sgp_pkg::*;

// Functional notes
// [RL1] Start: data falls while clock high
// [RL2] Stop: data rises while clock high
// [RL3] Address bits 7-1, direction bit 0
// [RL4] Direction and command select store or fetch
// [RL5] Bytes shift most significant bit first
// [RL6] Broadcast to charger and host addresses
// [RL7] Slave read word, write word, block read
// [RL8] Master broadcasts use write word only
// [RL9] Messages with or without PEC accepted
// [RL10] Last byte supplier appends PEC byte
// [RL11] Receiver compares PEC with own value
// [RL12] Host without PEC stops after data
// [RL13] PEC match acks, mismatch nacks, error
// [RL14] Host acks data, nacks PEC, stops
// [RL15] CRC-8 polynomial x8+x2+x+1
// [RL16] CRC covers address, command, data bytes
// [RL17] Bus off after 2 s low, on in 1 ms
// [RL18] Foreign address not acked, transfer ignored
// [RL19] Lost arbitration abandons broadcast
module sgp_port #(
  parameter int OFF_CYCLES = sgp_pkg::SGP_OFF_CYCLES,
  parameter int ON_CYCLES  = sgp_pkg::SGP_ON_CYCLES
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Bus pins, split into in/out/enable
  input  wire logic                serial_clock_line_i,
  output logic                     serial_clock_line_o,
  output logic                     serial_clock_line_oe,
  input  wire logic                serial_data_line_i,
  output logic                     serial_data_line_o,
  output logic                     serial_data_line_oe,
  // Slave access to gauge registers
  output sgp_pkg::sgp_req_t        req,
  output logic                     req_valid,
  output logic                     rd_req,
  output logic [7:0]               rd_cmd,
  input  wire logic [15:0]         rd_word,
  input  wire logic                rd_is_block,
  input  wire logic [7:0]          blk_data,
  output logic [4:0]               blk_index,
  input  wire logic [5:0]          blk_len,
  // Master broadcast requests
  input  wire logic                bc_valid,
  output logic                     bc_ready,
  input  wire sgp_pkg::sgp_bcast_t bc_data,
  input  wire logic                bc_pec_en,
  // Status
  output logic                     pec_error,
  output logic                     bc_done,
  output logic                     bc_lost,
  output logic                     bus_off
);
  import sgp_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_RX = 8'h02, ST_RACK = 8'h04, ST_TX = 8'h08,
    ST_TACK = 8'h10, ST_IGN = 8'h20, ST_MST = 8'h40, ST_MSTOP = 8'h80
  } sgp_state_t;

  sgp_state_t state;
  logic       scl, sda, scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] shreg;
  logic [2:0] bitn;
  logic [3:0] bytes;
  logic       dir_rd;
  logic [7:0] cmd;
  logic [7:0] crc;
  logic [15:0] wdata;
  logic       sda_drv;
  logic       scl_drv;
  logic [5:0] tx_left;
  logic       tx_last;
  logic [31:0] off_cnt;
  logic [31:0] on_cnt;
  logic       fifo_v;
  logic       bus_busy;
  sgp_bcast_t fq;
  logic [5:0] mbyte;
  logic [9:0] div;
  logic [1:0] phase;
  logic       tick;
  logic [7:0] mbuf;
  logic       mpec;
  logic       rep;
  logic       m_go;
  logic [7:0] m_addr;
  sgp_bcast_t cur;

  sgp_bit_sync u_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .scl_pin   (serial_clock_line_i),
    .sda_pin   (serial_data_line_i),
    .scl       (scl),
    .sda       (sda),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // Broadcast queue; drained only when the bus is free
  sgp_fifo #(.WIDTH($bits(sgp_bcast_t)), .DEPTH(SGP_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (bc_valid),
    .in_ready  (bc_ready),
    .in_data   (bc_data),
    .out_valid (fifo_v),
    .out_ready (m_go),
    .out_data  (fq)
  );

  // Open drain: drive only low
  assign serial_data_line_o   = 1'b0;
  assign serial_clock_line_o  = 1'b0;
  assign serial_data_line_oe  = sda_drv;
  assign serial_clock_line_oe = scl_drv;

  // Off-state detect and recovery timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      off_cnt <= '0;
      on_cnt  <= '0;
      bus_off <= 1'b0;
    end else if (!scl && !sda) begin
      on_cnt <= '0;
      if (off_cnt >= 32'(OFF_CYCLES - 1)) begin
        bus_off <= 1'b1; // RL17
      end else begin
        off_cnt <= off_cnt + 32'h1;
      end
    end else begin
      off_cnt <= '0;
      if (bus_off && scl && sda) begin
        if (on_cnt >= 32'(ON_CYCLES - 1)) begin
          bus_off <= 1'b0; // RL17
        end else begin
          on_cnt <= on_cnt + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_busy <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1;
    end else if (stop_det) begin
      bus_busy <= 1'b0;
    end
  end

  // Master bit clock enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div <= '0;
    end else begin
      div <= (div == 10'(SGP_MDIV - 1)) ? '0 : div + 10'h1;
    end
  end
  assign tick = (div == '0);

  assign tx_last = (tx_left == 6'h0);

  // Pop only when a broadcast really starts; a start seen in that cycle must not drop an entry
  assign m_go   = state == ST_IDLE && mbyte == 6'h3F && fifo_v && !bus_busy && !bus_off
                  && !start_det && !stop_det;
  assign m_addr = {fq.to_host ? SGP_HOST_ADDR : SGP_CHARGER_ADDR, 1'b0};

  // Slave and master protocol engine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      shreg     <= '0;
      bitn      <= '0;
      bytes     <= '0;
      dir_rd    <= 1'b0;
      cmd       <= '0;
      crc       <= SGP_CRC_INIT;
      wdata     <= '0;
      sda_drv   <= 1'b0;
      scl_drv   <= 1'b0;
      tx_left   <= '0;
      req       <= '0;
      req_valid <= 1'b0;
      rd_req    <= 1'b0;
      rd_cmd    <= '0;
      blk_index <= '0;
      pec_error <= 1'b0;
      bc_done   <= 1'b0;
      bc_lost   <= 1'b0;
      mbyte     <= 6'h3F;
      phase     <= '0;
      mbuf      <= '0;
      mpec      <= 1'b0;
      rep       <= 1'b0;
      cur       <= '0;
    end else begin
      req_valid <= 1'b0;
      rd_req    <= 1'b0;
      pec_error <= 1'b0;
      bc_done   <= 1'b0;
      bc_lost   <= 1'b0;
      if (mbyte != 6'h3F) begin
        // Master write word broadcast
        if (state == ST_MST && scl_drv == 1'b0 && scl && sda_drv == 1'b0
            && !sda && phase == 2'h3 && bytes != 4'h8) begin
          sda_drv <= 1'b0; // RL19
          scl_drv <= 1'b0;
          mbyte   <= 6'h3F;
          state   <= ST_IDLE;
          bc_lost <= 1'b1;
        end else if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: scl_drv <= 1'b1;
            2'h1: begin
              if (state == ST_MSTOP) begin
                sda_drv <= 1'b1;
              end else if (bitn == 3'h0 && bytes == 4'h8) begin
                sda_drv <= 1'b0;
              end else begin
                sda_drv <= !mbuf[7]; // RL5
              end
            end
            2'h2: scl_drv <= 1'b0;
            default: begin
              if (state == ST_MSTOP) begin
                sda_drv <= 1'b0; // RL2
                mbyte   <= 6'h3F;
                state   <= ST_IDLE;
                bc_done <= 1'b1;
              end else if (bytes == 4'h8) begin
                bytes <= '0;
                mbyte <= mbyte + 6'h1;
                if (mbyte == (mpec ? 6'h4 : 6'h3)) begin
                  state <= ST_MSTOP;
                end else begin
                  case (mbyte)
                    6'h0:    mbuf <= cur.cmd;
                    6'h1:    mbuf <= cur.data[7:0];
                    6'h2:    mbuf <= cur.data[15:8];
                    default: mbuf <= crc; // RL10
                  endcase
                  // Check byte taken at load; the shift register is mangled by the end
                  if (mbyte < 6'h3) begin
                    crc <= sgp_crc8(crc, (mbyte == 6'h0) ? cur.cmd
                      : (mbyte == 6'h1) ? cur.data[7:0] : cur.data[15:8]); // RL16
                  end
                  bitn <= 3'h7;
                end
              end else begin
                if (bitn == 3'h0) begin
                  bytes <= 4'h8;
                end else begin
                  bitn  <= bitn - 3'h1;
                  mbuf  <= {mbuf[6:0], 1'b0};
                end
              end
            end
          endcase
        end
      end else if (start_det) begin
        state <= ST_RX; // RL1
        bitn  <= 3'h7;
        // A start after address and command is a read's repeated start: keep the check
        rep   <= (bytes == 4'h2 && state != ST_IGN);
        if (bytes != 4'h2 || state == ST_IGN) begin
          bytes <= '0;
        end
        sda_drv <= 1'b0;
      end else if (stop_det) begin
        if (state != ST_IGN && !dir_rd && bytes == 4'h4) begin
          req_valid <= 1'b1; // RL12
          req       <= '{wr: 1'b1, cmd: cmd, data: wdata, pec: 1'b0};
        end
        state   <= ST_IDLE; // RL2
        bytes   <= '0;
        sda_drv <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (m_go) begin
              // RL6 RL8: address the charger or host with a write word
              mbuf    <= m_addr;
              crc     <= sgp_crc8(SGP_CRC_INIT, m_addr); // RL16
              cur     <= fq;
              mpec    <= bc_pec_en;
              mbyte   <= '0;
              bitn    <= 3'h7;
              bytes   <= '0;
              phase   <= '0;
              sda_drv <= 1'b1; // RL1
              state   <= ST_MST;
            end
          end
          ST_RX: if (scl_rise) begin
            shreg <= {shreg[6:0], sda}; // RL5
            if (bitn == 3'h0) begin
              state <= ST_RACK;
            end else begin
              bitn <= bitn - 3'h1;
            end
          end
          ST_RACK: if (scl_fall) begin
            bytes <= bytes + 4'h1;
            crc   <= (bytes == 4'h0) ? sgp_crc8(SGP_CRC_INIT, shreg)
                                     : sgp_crc8(crc, shreg); // RL15 RL16
            bitn  <= 3'h7;
            if (bytes == 4'h0 || (bytes == 4'h2 && rep)) begin
              if (shreg[7:1] != SGP_OWN_ADDR) begin
                state <= ST_IGN; // RL18
              end else begin
                sda_drv <= 1'b1; // RL3
                dir_rd  <= shreg[0];
                state   <= ST_TACK;
                if (shreg[0]) begin
                  rd_req <= 1'b1; // RL4
                  rd_cmd <= cmd;
                end
              end
            end else if (bytes == 4'h4) begin
              if (shreg == crc) begin
                sda_drv   <= 1'b1; // RL11 RL13
                req_valid <= 1'b1; // RL9
                req       <= '{wr: 1'b1, cmd: cmd, data: wdata, pec: 1'b1};
              end else begin
                pec_error <= 1'b1; // RL13
              end
              state <= ST_TACK;
            end else begin
              if (bytes == 4'h1) cmd <= shreg;
              if (bytes == 4'h2) wdata[7:0] <= shreg;
              if (bytes == 4'h3) wdata[15:8] <= shreg;
              sda_drv <= 1'b1;
              state   <= ST_TACK;
            end
          end
          ST_TACK: if (scl_fall) begin
            sda_drv <= 1'b0;
            if (dir_rd && bytes >= 4'h3) begin
              // RL7 RL14: byte out, PEC last; host nack ends it
              if (bytes == 4'h3) begin
                tx_left   <= rd_is_block ? blk_len : 6'h1;
                shreg     <= rd_is_block ? {2'h0, blk_len} : rd_word[7:0];
                crc       <= sgp_crc8(crc, rd_is_block ? {2'h0, blk_len} : rd_word[7:0]);
                blk_index <= '0;
              end
              state <= ST_TX;
              bitn  <= 3'h7;
            end else begin
              state <= ST_RX;
            end
          end
          ST_TX: begin
            sda_drv <= !shreg[7]; // RL5
            if (scl_fall) begin
              if (bitn == 3'h0) begin
                sda_drv <= 1'b0;
                state   <= ST_IGN;
                bytes   <= 4'h5;
              end else begin
                bitn  <= bitn - 3'h1;
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          ST_IGN: if (bytes == 4'h5 && scl_rise) begin
            if (sda) begin
              state <= ST_IGN; // RL14
              bytes <= 4'h6;
            end else begin
              // Wait for the acknowledge clock to fall, or that fall would count as a bit
              state   <= ST_TACK;
              bitn    <= 3'h7;
              bytes   <= 4'h3 + 4'h1;
              if (tx_last) begin
                shreg <= crc; // RL10
              end else begin
                tx_left   <= tx_left - 6'h1;
                blk_index <= blk_index + 5'h1;
                shreg     <= rd_is_block ? blk_data : rd_word[15:8];
                crc       <= sgp_crc8(crc, rd_is_block ? blk_data : rd_word[15:8]);
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  a_start_recv: assert property (@(posedge clk) disable iff (sys_rst)
    start_det && mbyte == 6'h3F |=> state == ST_RX) // RL1
    else $error("start not taken");
  a_stop_idle: assert property (@(posedge clk) disable iff (sys_rst)
    stop_det && mbyte == 6'h3F |=> state == ST_IDLE) // RL2
    else $error("stop not taken");
  a_pec_nack: assert property (@(posedge clk) disable iff (sys_rst)
    pec_error |-> !sda_drv) // RL13
    else $error("ack on bad pec");
  a_foreign_ign: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_IGN && bytes == 4'h1 |-> !sda_drv) // RL18
    else $error("drove foreign transfer");
  a_lost_release: assert property (@(posedge clk) disable iff (sys_rst)
    bc_lost |-> !sda_drv && !scl_drv) // RL19
    else $error("bus held after loss");
  a_off_set: assert property (@(posedge clk) disable iff (sys_rst)
    bus_off && !$past(bus_off) |-> $past(!scl && !sda)) // RL17
    else $error("off without low bus");
  a_req_write: assert property (@(posedge clk) disable iff (sys_rst)
    req_valid |-> req.wr && !dir_rd) // RL4
    else $error("write on read");
  a_rd_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    rd_req |-> rd_cmd == cmd) // RL4
    else $error("wrong read command");
  c_write: cover property (@(posedge clk) req_valid);
  c_read: cover property (@(posedge clk) rd_req);
  c_bcast: cover property (@(posedge clk) bc_done);
endmodule : sgp_port

// *** testbench/sgp_host_model.sv ***
// Bus host model: bit-level master tasks, bit monitor and a contending driver
`timescale 1ns/1ps
module sgp_host_model #(
  parameter time QTR = 12ns
) (
  // Wired bus levels
  input  wire logic scl,
  input  wire logic sda,
  // Pull-down enables
  output logic      scl_oe,
  output logic      sda_oe
);
  logic [7:0] cap;
  int         cnt;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    cap    = 8'h00;
    cnt    = 0;
  end

  // Bits seen since the last start, whoever drives them
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
    end
  end

  always @(posedge scl) begin
    cap = {cap[6:0], sda};
    cnt = cnt + 1;
  end

  // Clock stands still high between frames except in t_off, which sets scl_oe itself; otherwise only these tasks move it
  task automatic bit_x(input logic b, output logic r);
    sda_oe = !b;
    #QTR;
    scl_oe = 1'b0;
    #QTR;
    r = sda;
    #QTR;
    scl_oe = 1'b1;
    #QTR;
  endtask : bit_x

  // Extra wait first so a trailing acknowledge is gone before a repeated start
  task automatic start_c;
    sda_oe = 1'b0;
    #(2*QTR);
    scl_oe = 1'b0;
    #QTR;
    sda_oe = 1'b1;
    #QTR;
    scl_oe = 1'b1;
    #QTR;
  endtask : start_c

  task automatic stop_c;
    sda_oe = 1'b1;
    #QTR;
    scl_oe = 1'b0;
    #QTR;
    sda_oe = 1'b0;
    #(2*QTR);
  endtask : stop_c

  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : byte_w

  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask : byte_r

  // Pull data low from bit n on, so a transmitter sending a one loses
  task automatic contend(input int n);
    wait (cnt == n);
    @(negedge scl);
    #QTR;
    sda_oe = 1'b1;
  endtask : contend
endmodule : sgp_host_model

// *** testbench/smbus_gauge_port_with_pec_test.sv ***
// Self-checking bench for the gauge bus port
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module smbus_gauge_port_with_pec_test;
  import sgp_pkg::*;
  localparam int OFF_CYC = 2000;
  localparam int ON_CYC  = 200;
  localparam int LIMIT   = 60000;
  logic       clk, sys_rst = 1'b1;
  logic       scl_o, scl_oe, sda_o, sda_oe, hs_scl_oe, hs_sda_oe;
  sgp_req_t   req, got_req;
  logic       req_valid, rd_req, bc_ready, pec_error, bc_done, bc_lost, bus_off;
  logic [7:0] rd_cmd, blk_data = 8'h00;
  logic [4:0] blk_index;
  logic [15:0] rd_word = 16'h0000;
  logic       rd_is_block = 1'b0, bc_valid = 1'b0, bc_pec_en = 1'b0;
  logic [5:0] blk_len = 6'h00;
  sgp_bcast_t bc_data = '0;
  int         num_errors = 0, samples_checked = 0, cyc = 0, n_req = 0, n_perr = 0, n_lost = 0;
  wire        scl = !(scl_oe && !scl_o) && !hs_scl_oe;
  wire        sda = !(sda_oe && !sda_o) && !hs_sda_oe;

  sgp_port #(.OFF_CYCLES(OFF_CYC), .ON_CYCLES(ON_CYC)) dut (
    .clk(clk), .sys_rst(sys_rst),
    .serial_clock_line_i(scl), .serial_clock_line_o(scl_o), .serial_clock_line_oe(scl_oe),
    .serial_data_line_i(sda), .serial_data_line_o(sda_o), .serial_data_line_oe(sda_oe),
    .req(req), .req_valid(req_valid), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_word(rd_word),
    .rd_is_block(rd_is_block), .blk_data(blk_data), .blk_index(blk_index),
    .blk_len(blk_len), .bc_valid(bc_valid), .bc_ready(bc_ready), .bc_data(bc_data),
    .bc_pec_en(bc_pec_en), .pec_error(pec_error), .bc_done(bc_done), .bc_lost(bc_lost),
    .bus_off(bus_off));

  sgp_host_model host (.scl(scl), .sda(sda), .scl_oe(hs_scl_oe), .sda_oe(hs_sda_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction : crc

  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Pulses are one cycle wide, so they are counted here rather than polled
  always @(posedge clk) begin
    cyc++;
    if (req_valid === 1'b1) begin
      got_req = req;
      n_req++;
    end
    if (pec_error === 1'b1) n_perr++;
    if (bc_lost === 1'b1) n_lost++;
    if (cyc == LIMIT) begin
      num_errors++;
      test_done();
    end
  end

  always @(negedge clk) blk_data <= 8'hC0 + {3'b000, blk_index};

  // Write word without, with good and with corrupted check byte
  task automatic t_write;
    logic [7:0] p;
    logic       k;
    int         nr, ne;
    for (int m = 0; m < 3; m++) begin
      nr = n_req;
      ne = n_perr;
      p = crc(crc(crc(crc(8'h00, 8'h16), 8'h3C), 8'hA5), 8'h5A) ^ ((m == 2) ? 8'h01 : 8'h00);
      host.start_c();
      host.byte_w(8'h16, k);
      `CHK(k, 1'b1)
      host.byte_w(8'h3C, k);
      host.byte_w(8'hA5, k);
      host.byte_w(8'h5A, k);
      `CHK(k, 1'b1)
      if (m > 0) begin
        host.byte_w(p, k);
        `CHK(k, m == 1)
      end
      host.stop_c();
      repeat (10) @(negedge clk);
      `CHK(n_req - nr, (m == 2) ? 0 : 1)
      `CHK(n_perr - ne, (m == 2) ? 1 : 0)
      if (m < 2) `CHK(got_req, {1'b1, 8'h3C, 16'h5AA5, m == 1})
    end
  endtask : t_write

  task automatic t_foreign;
    logic k;
    int   nr;
    nr = n_req;
    host.start_c();
    host.byte_w(8'h18, k);
    `CHK(k, 1'b0)
    host.byte_w(8'h3C, k);
    `CHK(k, 1'b0)
    host.stop_c();
    repeat (10) @(negedge clk);
    `CHK(n_req - nr, 0)
  endtask : t_foreign

  task automatic rd_head(input logic [7:0] cmd);
    logic k;
    host.start_c();
    host.byte_w(8'h16, k);
    `CHK(k, 1'b1)
    host.byte_w(cmd, k);
    `CHK(k, 1'b1)
    host.start_c();
    host.byte_w(8'h17, k);
    `CHK(k, 1'b1)
  endtask : rd_head

  task automatic t_read;
    logic [7:0] lo, hi, pc;
    rd_word = 16'h03E9;
    rd_is_block = 1'b0;
    rd_head(8'h0F);
    host.byte_r(1'b0, lo);
    host.byte_r(1'b0, hi);
    host.byte_r(1'b1, pc);
    host.stop_c();
    `CHK(rd_cmd, 8'h0F)
    `CHK({hi, lo}, 16'h03E9)
    `CHK(pc, crc(crc(crc(crc(crc(8'h00, 8'h16), 8'h0F), 8'h17), 8'hE9), 8'h03))
  endtask : t_read

  task automatic t_block;
    logic [7:0] b, p;
    rd_is_block = 1'b1;
    blk_len = 6'h03;
    rd_head(8'h23);
    host.byte_r(1'b0, b);
    `CHK(b, 8'h03)
    p = crc(crc(crc(crc(8'h00, 8'h16), 8'h23), 8'h17), 8'h03);
    for (int i = 0; i < 3; i++) begin
      host.byte_r(1'b0, b);
      `CHK(b, 8'hC0 + i[7:0])
      p = crc(p, 8'hC0 + i[7:0]);
    end
    host.byte_r(1'b1, b);
    host.stop_c();
    `CHK(b, p)
    rd_is_block = 1'b0;
  endtask : t_block

  // Clock pulled low first so the pair never forms a start or stop
  task automatic t_off;
    host.scl_oe = 1'b1;
    #20;
    host.sda_oe = 1'b1;
    repeat (OFF_CYC - 20) @(negedge clk);
    `CHK(bus_off, 1'b0)
    repeat (40) @(negedge clk);
    `CHK(bus_off, 1'b1)
    host.sda_oe = 1'b0;
    #20;
    host.scl_oe = 1'b0;
    // Pin delay and synchroniser add a few cycles before the on-timer starts
    repeat (ON_CYC + 10) @(negedge clk);
    `CHK(bus_off, 1'b0)
  endtask : t_off

  // Queue fills until refused; the first broadcast then loses arbitration
  task automatic t_bcast;
    int acc, nl;
    acc = 0;
    nl = n_lost;
    bc_data = '{to_host: 1'b0, cmd: 8'h14, data: 16'h1234};
    bc_pec_en = 1'b1;
    bc_valid = 1'b1;
    repeat (12) begin
      @(negedge clk);
      if (bc_ready === 1'b1) acc++;
    end
    bc_valid = 1'b0;
    `CHK(bc_ready, 1'b0)
    `CHK(acc >= SGP_FIFO_DEPTH && acc <= SGP_FIFO_DEPTH + 1, 1'b1)
    host.contend(6);
    `CHK(host.cap[5:0], 6'b000100)
    for (int i = 0; i < 20000 && n_lost == nl; i++) @(negedge clk);
    `CHK(n_lost - nl, 1)
    repeat (4) @(negedge clk);
    `CHK(sda_oe, 1'b0)
    host.sda_oe = 1'b0;
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    `CHK(bc_ready, 1'b1)
  endtask : t_bcast

  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_write();
    t_foreign();
    t_read();
    t_block();
    t_off();
    t_bcast();
    test_done();
  end
endmodule : smbus_gauge_port_with_pec_test
